// ===== hw/flic_pkg.sv
// flic_pkg: constants, register map, vectors and types of the interrupt controller
// assumes: one 100 MHz clock, Avalon-MM slave with 32-bit data, 8-bit registers
// Overview of operation
// RULE1: nine sources, each with its own vector
// RULE2: per-source enables, global enable blocks all
// RULE3: high and low bits give levels 0 to 3
// RULE4: only strictly higher level pre-empts; top never
// RULE5: simultaneous requests: higher level served first
// RULE6: equal levels: fixed polling order decides
// RULE7: counter array 0033h, spi 0043h, keyboard 004bh
// RULE8: other sources use customary vectors 0003h..002bh
// RULE9: main enable: global, array, t2, serial, t1, x1, t0, x0
// RULE10: main enable resets zero, bit set/clear access
// RULE11: low priority register, bit 7 reserved, bit access
// RULE12: high priority register, same layout, resets zero
// RULE13: secondary enable: spi bit 2, keyboard bit 0
`default_nettype none

package flic_pkg;
    // ----------------------------------------------------------------
    // sizes
    // ----------------------------------------------------------------
    localparam int NUM_SRC = 9;
    localparam int ADDR_W = 10;
    localparam int DATA_W = 32;
    localparam int REG_W = 8;
    localparam int EVT_W = 4;
    localparam int NUM_LVL = 4;
    localparam int SYNC_W = 2;

    typedef logic [1:0] flic_level_t;
    typedef logic [3:0] flic_index_t;
    typedef enum logic [0:0] {CORE_IDLE = 1'b0, CORE_OFFER = 1'b1} flic_core_e;

    // ----------------------------------------------------------------
    // register indices; byte address is four times the index
    // ----------------------------------------------------------------
    localparam logic [7:0] IDX_ENABLE_MAIN = 8'ha8;
    localparam logic [7:0] IDX_PRIO_LOW = 8'hb8;
    localparam logic [7:0] IDX_PRIO_HIGH = 8'hb7;
    localparam logic [7:0] IDX_ENABLE_SEC = 8'hb1;
    localparam logic [7:0] IDX_EVENT_STATUS = 8'hc0;
    localparam logic [7:0] IDX_EVENT_MASK = 8'hc1;
    localparam logic [7:0] IDX_PRIO_SEC_LOW = 8'hc2;
    localparam logic [7:0] IDX_PRIO_SEC_HIGH = 8'hc3;
    localparam logic [7:0] IDX_CORE_STATE = 8'hc4;
    localparam logic [7:0] IDX_VECTOR = 8'hc5;
    localparam logic [7:0] IDX_ENABLE_SET = 8'hc8;
    localparam logic [7:0] IDX_ENABLE_CLR = 8'hc9;
    localparam logic [7:0] IDX_PLOW_SET = 8'hca;
    localparam logic [7:0] IDX_PLOW_CLR = 8'hcb;

    localparam logic [7:0] REG_RESET = 8'h00;
    localparam int BIT_GLOBAL = 7;
    localparam int BIT_SEC_SPI = 2;
    localparam int BIT_SEC_KBD = 0;
    localparam logic [7:0] PRIO_MASK = 8'h7f;
    localparam logic [7:0] SEC_MASK = 8'h05;

    // ----------------------------------------------------------------
    // sources in polling order, and their vectors
    // ----------------------------------------------------------------
    localparam flic_index_t SRC_EXT0 = 4'h0;
    localparam flic_index_t SRC_T0 = 4'h1;
    localparam flic_index_t SRC_EXT1 = 4'h2;
    localparam flic_index_t SRC_T1 = 4'h3;
    localparam flic_index_t SRC_SER = 4'h4;
    localparam flic_index_t SRC_T2 = 4'h5;
    localparam flic_index_t SRC_PCA = 4'h6;
    localparam flic_index_t SRC_SPI = 4'h7;
    localparam flic_index_t SRC_KBD = 4'h8;
    localparam int MAIN_SRCS = 7;

    localparam logic [15:0] VEC_EXT0 = 16'h0003;
    localparam logic [15:0] VEC_T0 = 16'h000b;
    localparam logic [15:0] VEC_EXT1 = 16'h0013;
    localparam logic [15:0] VEC_T1 = 16'h001b;
    localparam logic [15:0] VEC_SER = 16'h0023;
    localparam logic [15:0] VEC_T2 = 16'h002b;
    localparam logic [15:0] VEC_PCA = 16'h0033;
    localparam logic [15:0] VEC_SPI = 16'h0043;
    localparam logic [15:0] VEC_KBD = 16'h004b;

    // event bits of the status register
    localparam int EVT_TAKEN = 0;
    localparam int EVT_PREEMPT = 1;
    localparam int EVT_STRAY_RET = 2;
    localparam int EVT_WITHDRAWN = 3;

    function automatic logic [ADDR_W-1:0] byte_addr(input logic [7:0] idx);
        return {idx, 2'b00};
    endfunction

    function automatic logic [15:0] vector_of(input flic_index_t idx);
        unique case (idx)
            SRC_EXT0: return VEC_EXT0;
            SRC_T0: return VEC_T0;
            SRC_EXT1: return VEC_EXT1;
            SRC_T1: return VEC_T1;
            SRC_SER: return VEC_SER;
            SRC_T2: return VEC_T2;
            SRC_PCA: return VEC_PCA;
            SRC_SPI: return VEC_SPI;
            SRC_KBD: return VEC_KBD;
            default: return VEC_EXT0;
        endcase
    endfunction
endpackage

`default_nettype wire

// ===== hw/flic_arbiter.sv
// flic_arbiter: picks the winning request by level, then by polling order
// assumes: requests already gated by enables; purely combinational
`default_nettype none

module flic_arbiter #(
    parameter int NUM_SRC = flic_pkg::NUM_SRC
) (
    // gated requests and their priority bits
    input wire logic [NUM_SRC-1:0] req_in,
    input wire logic [NUM_SRC-1:0] prio_high_in,
    input wire logic [NUM_SRC-1:0] prio_low_in,
    // winner
    output logic valid_out,
    output flic_pkg::flic_index_t index_out,
    output flic_pkg::flic_level_t level_out
);
    // -------------------------------------------------------------
    // scan in polling order; a later source wins only on higher level
    // -------------------------------------------------------------
    always_comb begin
        flic_pkg::flic_level_t lvl;
        lvl = '0;
        valid_out = 1'b0;
        index_out = '0;
        level_out = '0;
        for (int i = 0; i < NUM_SRC; i++) begin
            lvl = {prio_high_in[i], prio_low_in[i]}; // RULE3
            if (req_in[i] && (!valid_out || lvl > level_out)) begin // RULE5 RULE6
                valid_out = 1'b1;
                index_out = flic_pkg::flic_index_t'(i);
                level_out = lvl;
            end
        end
    end
endmodule // flic_arbiter

`default_nettype wire

// ===== hw/flic_top.sv
// flic_top: four-level interrupt controller with Avalon-MM register slave
// assumes: peripheral requests on clk_sys_in, external pins asynchronous, core acks on clk_sys_in
`default_nettype none

module flic_top #(
    parameter int NUM_SRC = flic_pkg::NUM_SRC
) (
    // clock and reset
    input wire logic clk_sys_in,
    input wire logic reset_n_in,
    // avalon-mm slave
    input wire logic [flic_pkg::ADDR_W-1:0] avs_address_in,
    input wire logic avs_read_in,
    input wire logic avs_write_in,
    input wire logic [flic_pkg::DATA_W-1:0] avs_writedata_in,
    input wire logic [3:0] avs_byteenable_in,
    output logic [flic_pkg::DATA_W-1:0] avs_readdata_out,
    output logic avs_waitrequest_out,
    // request sources
    input wire logic [flic_pkg::SYNC_W-1:0] external_request_n_in,
    input wire logic timer0_req_in,
    input wire logic timer1_req_in,
    input wire logic timer2_req_in,
    input wire logic serial_req_in,
    input wire logic counter_array_req_in,
    input wire logic spi_req_in,
    input wire logic keyboard_req_in,
    output logic [NUM_SRC-1:0] src_ack_out,
    // cpu core
    input wire logic cpu_ack_in,
    input wire logic cpu_reti_in,
    output logic cpu_irq_out,
    output logic [15:0] cpu_vector_out,
    // event interrupt
    output logic irq_out
);
    // ----------------------------------------------------------------
    // declarations
    // ----------------------------------------------------------------
    logic [7:0] en_main_q, en_sec_q, plow_q, phigh_q, psec_low_q, psec_high_q;
    logic [flic_pkg::EVT_W-1:0] status_q, mask_q, evt_set;
    logic [flic_pkg::SYNC_W-1:0] sync1_q, sync2_q, sync3_q, ext_level_q;
    logic [NUM_SRC-1:0] raw_req, en_vec, gated_req, phi_vec, plo_vec;
    logic [flic_pkg::NUM_LVL-1:0] inserv_q, inserv_d;
    logic arb_valid, eligible, access, hit_status, cur_valid;
    flic_pkg::flic_index_t arb_idx, idx_q;
    flic_pkg::flic_level_t arb_lvl, lvl_q, cur_lvl;
    flic_pkg::flic_core_e state_q;
    logic [7:0] rd_val, wr_byte, word_idx;
    logic waitreq_q, irq_q, irq_out_q;
    logic [15:0] vec_q;
    logic [NUM_SRC-1:0] ack_q;
    logic [flic_pkg::DATA_W-1:0] rdata_q;
    logic higher_q, earlier_q;
    logic [NUM_SRC-1:0] gated_prev_q, phi_prev_q, plo_prev_q;

    // highest level currently in service
    function automatic logic [2:0] top_level(input logic [flic_pkg::NUM_LVL-1:0] ins);
        logic [2:0] r;
        r = '0;
        for (int l = 0; l < flic_pkg::NUM_LVL; l++) begin
            if (ins[l]) begin
                r = {1'b1, flic_pkg::flic_level_t'(l)};
            end
        end
        return r;
    endfunction

    assign {cur_valid, cur_lvl} = top_level(inserv_q);

    // ----------------------------------------------------------------
    // external pin synchroniser, filtered once stages two and three agree
    // ----------------------------------------------------------------
    always_ff @(posedge clk_sys_in) begin
        if (!reset_n_in) begin
            sync1_q <= '1;
            sync2_q <= '1;
            sync3_q <= '1;
            ext_level_q <= '1;
        end else begin
            sync1_q <= external_request_n_in;
            sync2_q <= sync1_q;
            sync3_q <= sync2_q;
            ext_level_q <= (sync2_q & ~(sync2_q ^ sync3_q)) | (ext_level_q & (sync2_q ^ sync3_q));
        end
    end

    // ----------------------------------------------------------------
    // request gathering, enables and priority vectors
    // ----------------------------------------------------------------
    assign raw_req = {keyboard_req_in, spi_req_in, counter_array_req_in, timer2_req_in, serial_req_in,
                      timer1_req_in, ~ext_level_q[1], timer0_req_in, ~ext_level_q[0]}; // RULE1
    assign en_vec = {en_sec_q[flic_pkg::BIT_SEC_KBD], en_sec_q[flic_pkg::BIT_SEC_SPI],
                     en_main_q[flic_pkg::MAIN_SRCS-1:0]}; // RULE9 RULE13
    assign gated_req = raw_req & en_vec & {NUM_SRC{en_main_q[flic_pkg::BIT_GLOBAL]}}; // RULE2
    assign phi_vec = {psec_high_q[flic_pkg::BIT_SEC_KBD], psec_high_q[flic_pkg::BIT_SEC_SPI],
                      phigh_q[flic_pkg::MAIN_SRCS-1:0]}; // RULE12
    assign plo_vec = {psec_low_q[flic_pkg::BIT_SEC_KBD], psec_low_q[flic_pkg::BIT_SEC_SPI],
                      plow_q[flic_pkg::MAIN_SRCS-1:0]}; // RULE11

    flic_arbiter #(
        .NUM_SRC(NUM_SRC)
    ) u_arbiter (
        .req_in(gated_req),
        .prio_high_in(phi_vec),
        .prio_low_in(plo_vec),
        .valid_out(arb_valid),
        .index_out(arb_idx),
        .level_out(arb_lvl)
    );

    // only a strictly higher level than the one in service is offered
    assign eligible = arb_valid && (!cur_valid || arb_lvl > cur_lvl); // RULE4

    // ----------------------------------------------------------------
    // offer to the core: irq, vector, index and level
    // ----------------------------------------------------------------
    always_ff @(posedge clk_sys_in) begin
        if (!reset_n_in) begin
            state_q <= flic_pkg::CORE_IDLE;
            irq_q <= 1'b0;
            vec_q <= '0;
            idx_q <= '0;
            lvl_q <= '0;
        end else if (cpu_ack_in && irq_q) begin
            state_q <= flic_pkg::CORE_IDLE; // taken; drop for one cycle
            irq_q <= 1'b0;
        end else if (eligible) begin
            state_q <= flic_pkg::CORE_OFFER;
            irq_q <= 1'b1;
            vec_q <= flic_pkg::vector_of(arb_idx); // RULE7 RULE8
            idx_q <= arb_idx;
            lvl_q <= arb_lvl;
        end else begin
            state_q <= flic_pkg::CORE_IDLE;
            irq_q <= 1'b0;
        end
    end

    // in-service levels: return clears top, acceptance sets offered level
    always_comb begin
        inserv_d = inserv_q;
        if (cpu_reti_in && cur_valid) begin
            inserv_d[cur_lvl] = 1'b0;
        end
        if (cpu_ack_in && irq_q) begin
            inserv_d[lvl_q] = 1'b1; // RULE4
        end
    end

    always_ff @(posedge clk_sys_in) begin
        if (!reset_n_in) begin
            inserv_q <= '0;
        end else begin
            inserv_q <= inserv_d;
        end
    end

    // one-cycle acknowledge to the source that was taken
    always_ff @(posedge clk_sys_in) begin
        if (!reset_n_in) begin
            ack_q <= '0;
        end else begin
            ack_q <= (cpu_ack_in && irq_q) ? NUM_SRC'(1) << idx_q : '0; // RULE1
        end
    end

    // ----------------------------------------------------------------
    // avalon-mm slave: one wait cycle, then the access edge
    // ----------------------------------------------------------------
    assign access = (avs_read_in || avs_write_in) && !waitreq_q;
    assign word_idx = avs_address_in[flic_pkg::ADDR_W-1:2];
    assign wr_byte = avs_writedata_in[flic_pkg::REG_W-1:0];

    always_ff @(posedge clk_sys_in) begin
        if (!reset_n_in) begin
            waitreq_q <= 1'b1;
        end else begin
            waitreq_q <= !((avs_read_in || avs_write_in) && waitreq_q);
        end
    end

    // read mux
    always_comb begin
        unique case (word_idx)
            flic_pkg::IDX_ENABLE_MAIN: rd_val = en_main_q;
            flic_pkg::IDX_ENABLE_SEC: rd_val = en_sec_q;
            flic_pkg::IDX_PRIO_LOW: rd_val = plow_q;
            flic_pkg::IDX_PRIO_HIGH: rd_val = phigh_q;
            flic_pkg::IDX_PRIO_SEC_LOW: rd_val = psec_low_q;
            flic_pkg::IDX_PRIO_SEC_HIGH: rd_val = psec_high_q;
            flic_pkg::IDX_EVENT_STATUS: rd_val = 8'(status_q);
            flic_pkg::IDX_EVENT_MASK: rd_val = 8'(mask_q);
            flic_pkg::IDX_CORE_STATE: rd_val = {2'h0, state_q, irq_q, inserv_q};
            flic_pkg::IDX_VECTOR: rd_val = vec_q[7:0];
            default: rd_val = 8'h00; // unmapped reads zero
        endcase
    end

    // read data prepared in the wait cycle, held through the access edge
    always_ff @(posedge clk_sys_in) begin
        if (!reset_n_in) begin
            rdata_q <= '0;
        end else if (avs_read_in && waitreq_q) begin
            rdata_q <= flic_pkg::DATA_W'(rd_val);
        end
    end

    // writes at the access edge, low byte lane only
    always_ff @(posedge clk_sys_in) begin
        if (!reset_n_in) begin
            en_main_q <= flic_pkg::REG_RESET; // RULE10
            en_sec_q <= flic_pkg::REG_RESET;
            plow_q <= flic_pkg::REG_RESET;
            phigh_q <= flic_pkg::REG_RESET;
            psec_low_q <= flic_pkg::REG_RESET;
            psec_high_q <= flic_pkg::REG_RESET;
            mask_q <= '0;
        end else if (access && avs_write_in && avs_byteenable_in[0]) begin
            unique case (word_idx)
                flic_pkg::IDX_ENABLE_MAIN: en_main_q <= wr_byte; // RULE9
                flic_pkg::IDX_ENABLE_SET: en_main_q <= en_main_q | wr_byte; // RULE10
                flic_pkg::IDX_ENABLE_CLR: en_main_q <= en_main_q & ~wr_byte; // RULE10
                flic_pkg::IDX_ENABLE_SEC: en_sec_q <= wr_byte & flic_pkg::SEC_MASK; // RULE13
                flic_pkg::IDX_PRIO_LOW: plow_q <= wr_byte & flic_pkg::PRIO_MASK; // RULE11
                flic_pkg::IDX_PLOW_SET: plow_q <= (plow_q | wr_byte) & flic_pkg::PRIO_MASK; // RULE11
                flic_pkg::IDX_PLOW_CLR: plow_q <= plow_q & ~wr_byte; // RULE11
                flic_pkg::IDX_PRIO_HIGH: phigh_q <= wr_byte & flic_pkg::PRIO_MASK; // RULE12
                flic_pkg::IDX_PRIO_SEC_LOW: psec_low_q <= wr_byte & flic_pkg::SEC_MASK;
                flic_pkg::IDX_PRIO_SEC_HIGH: psec_high_q <= wr_byte & flic_pkg::SEC_MASK;
                flic_pkg::IDX_EVENT_MASK: mask_q <= wr_byte[flic_pkg::EVT_W-1:0];
                default: ; // read-only or unmapped: ignored
            endcase
        end
    end

    // ----------------------------------------------------------------
    // sticky event status, cleared by read, set wins over clear
    // ----------------------------------------------------------------
    always_comb begin
        evt_set = '0;
        evt_set[flic_pkg::EVT_TAKEN] = cpu_ack_in && irq_q;
        evt_set[flic_pkg::EVT_PREEMPT] = cpu_ack_in && irq_q && cur_valid;
        evt_set[flic_pkg::EVT_STRAY_RET] = cpu_reti_in && !cur_valid;
        evt_set[flic_pkg::EVT_WITHDRAWN] = irq_q && !cpu_ack_in && !eligible;
    end

    assign hit_status = access && avs_read_in && word_idx == flic_pkg::IDX_EVENT_STATUS;

    always_ff @(posedge clk_sys_in) begin
        if (!reset_n_in) begin
            status_q <= '0;
        end else if (hit_status) begin
            status_q <= (status_q & ~rdata_q[flic_pkg::EVT_W-1:0]) | evt_set; // only what was read
        end else begin
            status_q <= status_q | evt_set;
        end
    end

    always_ff @(posedge clk_sys_in) begin
        if (!reset_n_in) begin
            irq_out_q <= 1'b0;
        end else begin
            irq_out_q <= |(status_q & mask_q);
        end
    end

    // outputs straight from flops
    assign avs_readdata_out = rdata_q;
    assign avs_waitrequest_out = waitreq_q;
    assign src_ack_out = ack_q;
    assign cpu_irq_out = irq_q;
    assign cpu_vector_out = vec_q;
    assign irq_out = irq_out_q;

    // ----------------------------------------------------------------
    // checks: helper state seen one cycle earlier
    // ----------------------------------------------------------------
    always_ff @(posedge clk_sys_in) begin
        logic hi, ea;
        hi = 1'b0;
        ea = 1'b0;
        for (int j = 0; j < NUM_SRC; j++) begin
            if (gated_req[j] && {phi_vec[j], plo_vec[j]} > arb_lvl) begin
                hi = 1'b1;
            end
            if (gated_req[j] && {phi_vec[j], plo_vec[j]} == arb_lvl && j < int'(arb_idx)) begin
                ea = 1'b1;
            end
        end
        higher_q <= hi;
        earlier_q <= ea;
        gated_prev_q <= gated_req;
        phi_prev_q <= phi_vec;
        plo_prev_q <= plo_vec;
    end

    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (!reset_n_in);

    a_src_ack_pulse: assert property (cpu_ack_in && irq_q |=> $onehot(ack_q) ##1 ack_q == '0) // RULE1
        else $error("source acknowledge not a single one-hot pulse");
    a_global_blocks: assert property (!en_main_q[flic_pkg::BIT_GLOBAL] |=> !irq_q) // RULE2
        else $error("request offered while global enable clear");
    a_offer_enabled: assert property (irq_q |-> gated_prev_q[idx_q]) // RULE2
        else $error("offered source was not enabled and pending");
    a_level_from_bits: assert property (irq_q |-> lvl_q == {phi_prev_q[idx_q], plo_prev_q[idx_q]}) // RULE3
        else $error("offered level does not match priority bits");
    a_preempt_strict: assert property (irq_q && cur_valid |-> lvl_q > cur_lvl) // RULE4
        else $error("offer does not exceed level in service");
    a_top_level_holds: assert property (inserv_q[flic_pkg::NUM_LVL-1] |-> !irq_q) // RULE4
        else $error("top-level handler pre-empted");
    a_higher_first: assert property (irq_q |-> !higher_q) // RULE5
        else $error("a higher-level request was passed over");
    a_polling_order: assert property (irq_q |-> !earlier_q) // RULE6
        else $error("earlier source at equal level was passed over");
    a_vector_new: assert property (irq_q && idx_q == flic_pkg::SRC_SPI |-> vec_q == flic_pkg::VEC_SPI) // RULE7
        else $error("wrong spi vector");
    a_vector_base: assert property (irq_q && idx_q == flic_pkg::SRC_T1 |-> vec_q == flic_pkg::VEC_T1) // RULE8
        else $error("wrong timer 1 vector");
    a_enable_reset: assert property ($rose(reset_n_in) |-> en_main_q == flic_pkg::REG_RESET) // RULE10
        else $error("main enable not zero after reset");
    a_prio_reserved: assert property ((plow_q & ~flic_pkg::PRIO_MASK) == 8'h00) // RULE11
        else $error("reserved priority bit set");
    a_sec_reserved: assert property ((en_sec_q & ~flic_pkg::SEC_MASK) == 8'h00 ##1 phigh_q[7] == 1'b0) // RULE13
        else $error("reserved enable bit set");
    a_bus_answer: assert property ((avs_read_in || avs_write_in) && waitreq_q |=> !waitreq_q ##1 waitreq_q)
        else $error("bus answer not after one wait cycle");
endmodule // flic_top

`default_nettype wire

// ===== dv/flic_cpu_model.sv
// flic_cpu_model: request sources and a core that takes offers
// assumes: flic_top core side on the same clock, level requests
`default_nettype none

module flic_cpu_model (
    // clock and reset
    input wire logic clk_sys_in,
    input wire logic reset_n_in,
    // bench control: one-cycle raise pulses, core willing to ack
    input wire logic [8:0] fire_in,
    input wire logic go_in,
    // controller side
    input wire logic cpu_irq_in,
    input wire logic [15:0] cpu_vector_in,
    input wire logic [8:0] src_ack_in,
    output logic [8:0] req_out,
    output logic cpu_ack_out,
    output logic [15:0] vec_out
);
    timeunit 1ns;
    timeprecision 1ps;

    // sources hold their level until serviced
    always_ff @(posedge clk_sys_in) begin
        if (!reset_n_in) begin
            req_out <= 9'h000;
        end else begin
            req_out <= (req_out & ~src_ack_in) | fire_in;
        end
    end

    // one ack per standing offer; a slow core just holds go low
    always_ff @(posedge clk_sys_in) begin
        if (!reset_n_in) begin
            cpu_ack_out <= 1'b0;
            vec_out <= 16'h0000;
        end else begin
            cpu_ack_out <= cpu_irq_in && go_in && !cpu_ack_out;
            if (cpu_ack_out && cpu_irq_in) begin
                vec_out <= cpu_vector_in;
            end
        end
    end
endmodule // flic_cpu_model

`default_nettype wire

// ===== dv/flic_top_bench.sv
// flic_top_bench: self-checking bench for the interrupt controller
// assumes: flic_cpu_model plays core and sources; 100 MHz clock
`default_nettype none

module flic_top_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_sys_in, reset_n_in, avs_read_in, avs_write_in, avs_waitrequest_out, go;
    logic cpu_ack_in, cpu_reti_in, cpu_irq_out, irq_out;
    logic [9:0] avs_address_in;
    logic [31:0] avs_writedata_in, avs_readdata_out;
    logic [3:0] avs_byteenable_in;
    logic [8:0] fire, req, src_ack_out;
    logic [15:0] cpu_vector_out, vec;
    int bad_count = 0;
    int checks = 0;
    logic [15:0] vt [9] = '{16'h0003, 16'h000b, 16'h0013, 16'h001b, 16'h0023, 16'h002b, 16'h0033, 16'h0043, 16'h004b};
    logic [7:0] ri [5] = '{8'ha8, 8'hb8, 8'hb7, 8'hb1, 8'h10};
    logic [7:0] rm [5] = '{8'hff, 8'h7f, 8'h7f, 8'h05, 8'h00};

    // design and its far side
    flic_top flic_top_i (.clk_sys_in, .reset_n_in, .avs_address_in, .avs_read_in, .avs_write_in,
        .avs_writedata_in, .avs_byteenable_in, .avs_readdata_out, .avs_waitrequest_out,
        .external_request_n_in(~{req[2], req[0]}), .timer0_req_in(req[1]), .timer1_req_in(req[3]),
        .serial_req_in(req[4]), .timer2_req_in(req[5]), .counter_array_req_in(req[6]),
        .spi_req_in(req[7]), .keyboard_req_in(req[8]), .src_ack_out, .cpu_ack_in, .cpu_reti_in,
        .cpu_irq_out, .cpu_vector_out, .irq_out);
    flic_cpu_model flic_cpu_model_i (.clk_sys_in, .reset_n_in, .fire_in(fire), .go_in(go),
        .cpu_irq_in(cpu_irq_out), .cpu_vector_in(cpu_vector_out), .src_ack_in(src_ack_out),
        .req_out(req), .cpu_ack_out(cpu_ack_in), .vec_out(vec));

    // clock
    initial begin
        clk_sys_in = 1'b0;
        forever #5 clk_sys_in = ~clk_sys_in;
    end

    task automatic report_and_stop;
        $display("bad_count=%0d checks=%0d", bad_count, checks);
        if (bad_count == 0 && checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    task automatic fail_if(input logic b, input string m);
        checks++;
        if (b !== 1'b0) begin
            bad_count++;
            $display("MISMATCH %0t %s", $time, m);
        end
    endtask

    task automatic chk_reg(input logic [7:0] g, input logic [7:0] e);
        fail_if(g !== e, "register value");
    endtask

    task automatic chk_vec(input logic [15:0] g, input logic [15:0] e);
        fail_if(g !== e, "vector or ack");
    endtask

    // one avalon access, held until waitrequest is seen low
    task automatic bus(input logic wr, input logic [7:0] idx, input logic [7:0] wd, output logic [7:0] rd);
        int n;
        n = 0;
        avs_address_in <= {idx, 2'b00};
        avs_writedata_in <= {24'h000000, wd};
        avs_write_in <= wr;
        avs_read_in <= !wr;
        do begin
            @(posedge clk_sys_in);
            n++;
        end while (avs_waitrequest_out !== 1'b0 && n < 50);
        if (avs_waitrequest_out !== 1'b0) begin
            fail_if(1'b1, "bus timeout");
            report_and_stop();
        end
        rd = avs_readdata_out[7:0];
        avs_write_in <= 1'b0;
        avs_read_in <= 1'b0;
        @(posedge clk_sys_in);
    endtask

    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        logic [7:0] x;
        bus(1'b1, idx, d, x);
    endtask

    // wait for the source ack, then judge it and the vector taken
    task automatic take(input int i);
        int n;
        n = 0;
        while (src_ack_out === 9'h000 && n < 40) begin
            @(posedge clk_sys_in);
            n++;
        end
        if (n >= 40) begin
            fail_if(1'b1, "no offer taken");
            report_and_stop();
        end
        chk_vec({7'h00, src_ack_out}, 16'h0001 << i);
        chk_vec(vec, vt[i]);
    endtask

    task automatic idle;
        repeat (10) begin
            @(posedge clk_sys_in);
            fail_if(cpu_irq_out !== 1'b0, "unexpected offer");
        end
    endtask

    // let a dropped pin request clear the synchroniser first
    task automatic reti;
        repeat (4) @(posedge clk_sys_in);
        cpu_reti_in <= 1'b1;
        @(posedge clk_sys_in);
        cpu_reti_in <= 1'b0;
        @(posedge clk_sys_in);
    endtask

    task automatic raise(input logic [8:0] m);
        fire <= m;
        @(posedge clk_sys_in);
        fire <= 9'h000;
    endtask

    // main sequence
    initial begin
        logic [7:0] r;
        int i;
        {avs_read_in, avs_write_in, cpu_reti_in, go, reset_n_in} = 5'h00;
        {avs_address_in, avs_writedata_in, fire} = '0;
        avs_byteenable_in = 4'hf;
        repeat (8) @(posedge clk_sys_in);
        reset_n_in <= 1'b1;
        repeat (2) @(posedge clk_sys_in);
        // reset values, reserved bits, unmapped place
        for (i = 0; i < 5; i++) begin
            bus(1'b0, ri[i], 8'h00, r);
            chk_reg(r, 8'h00);
            wr(ri[i], 8'hff);
            bus(1'b0, ri[i], 8'h00, r);
            chk_reg(r, rm[i]);
        end
        wr(8'hb8, 8'h00);
        wr(8'hb7, 8'h00);
        // all sources at once with a slow core: polling order and vectors
        raise(9'h1ff);
        repeat (6) @(posedge clk_sys_in);
        go <= 1'b1;
        for (i = 0; i < 9; i++) begin
            take(i);
            reti();
        end
        // global and per-source enables
        go <= 1'b0;
        wr(8'ha8, 8'h7f);
        raise(9'h082);
        idle();
        wr(8'hb1, 8'h01);
        wr(8'ha8, 8'hfd);
        idle();
        wr(8'hc8, 8'h02);
        bus(1'b0, 8'ha8, 8'h00, r);
        chk_reg(r, 8'hff);
        wr(8'hb1, 8'h05);
        go <= 1'b1;
        take(1);
        reti();
        take(7);
        reti();
        // levels: t0 and t2 at 1, serial 2, t1 3
        wr(8'hca, 8'h2a);
        wr(8'hb7, 8'h18);
        raise(9'h012);
        take(4);
        raise(9'h128);
        take(3);
        idle();
        reti();
        idle();
        reti();
        take(1);
        idle();
        reti();
        take(5);
        reti();
        take(8);
        reti();
        // bit set and clear aliases
        wr(8'hcb, 8'h08);
        bus(1'b0, 8'hb8, 8'h00, r);
        chk_reg(r, 8'h22);
        wr(8'hc9, 8'h80);
        bus(1'b0, 8'ha8, 8'h00, r);
        chk_reg(r, 8'h7f);
        wr(8'hc8, 8'h80);
        // event interrupt: raised, cleared by read, then masked
        bus(1'b0, 8'hc0, 8'h00, r);
        wr(8'hc1, 8'h01);
        for (i = 0; i < 2; i++) begin
            raise(9'h002);
            take(1);
            reti();
            repeat (2) @(posedge clk_sys_in);
            chk_reg({7'h00, irq_out}, {7'h00, ~i[0]});
            bus(1'b0, 8'hc0, 8'h00, r);
            chk_reg(r & 8'h01, 8'h01);
            repeat (2) @(posedge clk_sys_in);
            chk_reg({7'h00, irq_out}, 8'h00);
            wr(8'hc1, 8'h00);
        end
        report_and_stop();
    end
endmodule // flic_top_bench

`default_nettype wire
